//--- hw/lcg_pkg.sv
// package for the logic cell input gating block: register map, field layout,
// reset values and the carrier types shared by the top module and its gate.
// assumes a 32-bit apb slave port with word-aligned registers.
package lcg_pkg;

	// apb address and data widths
	localparam int LCG_ADDR_W = 12;
	localparam int LCG_DATA_W = 32;

	// register byte offsets
	localparam logic [11:0] LCG_OFS_DATA_THREE_SEL = 12'h0000;
	localparam logic [11:0] LCG_OFS_DATA_FOUR_SEL = 12'h0004;
	localparam logic [11:0] LCG_OFS_GATE_ZERO_EN = 12'h0008;

	// source code field: bits 5..0, bits 7..6 unimplemented
	localparam int LCG_SRC_LSB = 0;
	localparam int LCG_SRC_W = 6;
	localparam int LCG_SRC_COUNT = 64;

	// gate zero enable bit positions
	localparam int LCG_G0_IN4_TRUE_BIT = 7;
	localparam int LCG_G0_IN4_INV_BIT = 6;
	localparam int LCG_G0_IN3_TRUE_BIT = 5;
	localparam int LCG_G0_IN3_INV_BIT = 4;
	localparam int LCG_GATE_W = 8;

	// read data driven while reset is held, and read data of unmapped words
	localparam logic [31:0] LCG_PRDATA_RST = 32'h0000_0000;
	localparam logic [31:0] LCG_UNMAPPED_RD = 32'h0000_0000;

	// gate zero enables as software writes them
	typedef struct packed {
		logic g0_in4_true_enable;
		logic g0_in4_inverted_enable;
		logic g0_in3_true_enable;
		logic g0_in3_inverted_enable;
		logic [3:0] low_data_enables;
	} lcg_gate_en_type;

	// data lines and gate result handed to the rest of the cell
	typedef struct packed {
		logic cell_data_line_three;
		logic cell_data_line_four;
		logic gate_zero;
	} lcg_cell_out_type;

	localparam lcg_cell_out_type LCG_CELL_OUT_RST = '{default: 1'b0};

endpackage

//--- hw/lcg_gate_zero.sv
// gate zero data term combiner for the logic cell.
// assumes the selected data lines and enables are stable within the cycle.
`timescale 1ns/1ps
`default_nettype none

module lcg_gate_zero
	import lcg_pkg::*;
(
	// selected data lines
	input wire logic line_three,
	input wire logic line_four,
	// software gating enables
	input wire lcg_gate_en_type gate_en,
	// combined result
	output logic gate_zero
);

	// or of every enabled true or inverted term; a cleared enable drops its term
	always_comb begin
		gate_zero = (gate_en.g0_in4_true_enable & line_four)
			| (gate_en.g0_in4_inverted_enable & ~line_four)
			| (gate_en.g0_in3_true_enable & line_three)
			| (gate_en.g0_in3_inverted_enable & ~line_three);
	end

endmodule

`default_nettype wire

//--- hw/lcg_input_gating.sv
// top of the logic cell input gating block: apb register file, data three and
// four source selection, and the registered gate zero result.
// assumes an apb master on pclk and a 64-wide source vector synchronous to pclk.
`timescale 1ns/1ps
`default_nettype none

module lcg_input_gating
	import lcg_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [lcg_pkg::LCG_ADDR_W-1:0] paddr,
	input wire logic [lcg_pkg::LCG_DATA_W-1:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic pready,
	output logic [lcg_pkg::LCG_DATA_W-1:0] prdata,
	output logic pslverr,
	// candidate sources for the data lines
	input wire logic [lcg_pkg::LCG_SRC_COUNT-1:0] source_bus,
	// lines and gate result toward the logic function core
	output lcg_pkg::lcg_cell_out_type cell_out
);
	import lcg_pkg::*;

	// register decode, used for both read mux and write enables
	typedef enum {
		LCG_REG_THREE,
		LCG_REG_FOUR,
		LCG_REG_GATE,
		LCG_REG_NONE
	} lcg_reg_sel_type;

	function automatic lcg_reg_sel_type lcg_decode(input logic [LCG_ADDR_W-1:0] addr);
		unique case (addr)
			LCG_OFS_DATA_THREE_SEL: lcg_decode = LCG_REG_THREE;
			LCG_OFS_DATA_FOUR_SEL: lcg_decode = LCG_REG_FOUR;
			LCG_OFS_GATE_ZERO_EN: lcg_decode = LCG_REG_GATE;
			default: lcg_decode = LCG_REG_NONE;
		endcase
	endfunction

	// pick one source by its code; same path for line three and line four
	function automatic logic lcg_pick(input logic [LCG_SRC_COUNT-1:0] src,
		input logic [LCG_SRC_W-1:0] code);
		lcg_pick = src[code];
	endfunction

	// configuration registers; no reset on purpose, see below
	logic [LCG_SRC_W-1:0] three_code_q, three_code_d; // third_input_source_code
	logic [LCG_SRC_W-1:0] four_code_q, four_code_d; // fourth_input_source_code
	lcg_gate_en_type gate_en_q, gate_en_d; // gate_zero_input_enable

	// apb answer registers
	logic pready_q, pready_d;
	logic [LCG_DATA_W-1:0] prdata_q, prdata_d;
	logic pslverr_q, pslverr_d;

	// output registers
	lcg_cell_out_type cell_q, cell_d;

	// bus decode terms
	lcg_reg_sel_type setup_sel; // register addressed in this cycle
	logic setup_phase; // first cycle of a transfer
	logic access_done; // edge at which the transfer completes
	logic wr_done; // write takes effect at this edge
	logic gate_now; // combinational gate zero result
	logic line_three_now; // selected data line three
	logic line_four_now; // selected data line four

	assign setup_sel = lcg_decode(paddr);
	assign setup_phase = psel & ~penable;
	// zero wait: pready is raised for the first access cycle only
	assign access_done = psel & penable & pready_q;
	assign wr_done = access_done & pwrite & pstrb[0];

	// apb answer: ready, read data and error are all prepared in the setup
	// cycle so that they come straight from flip-flops in the access cycle
	always_comb begin
		pready_d = setup_phase;
		prdata_d = LCG_PRDATA_RST;
		pslverr_d = 1'b0;
		if (setup_phase) begin
			unique case (setup_sel)
				LCG_REG_THREE: begin
					// upper bits are not stored, so they read zero
					prdata_d[LCG_SRC_LSB +: LCG_SRC_W] = three_code_q;
				end
				LCG_REG_FOUR: begin
					prdata_d[LCG_SRC_LSB +: LCG_SRC_W] = four_code_q;
				end
				LCG_REG_GATE: begin
					prdata_d[LCG_GATE_W-1:0] = gate_en_q;
				end
				LCG_REG_NONE: begin
					// unmapped: error answer, reads zero, writes dropped
					prdata_d = LCG_UNMAPPED_RD;
					pslverr_d = 1'b1;
				end
			endcase
			// write data is not returned on a write
			if (pwrite) begin
				prdata_d = LCG_PRDATA_RST;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			prdata_q <= LCG_PRDATA_RST;
			pslverr_q <= 1'b0;
		end else begin
			pready_q <= pready_d;
			prdata_q <= prdata_d;
			pslverr_q <= pslverr_d;
		end
	end

	// configuration writes; only byte lane 0 holds implemented bits
	always_comb begin
		three_code_d = three_code_q;
		four_code_d = four_code_q;
		gate_en_d = gate_en_q;
		if (wr_done) begin
			unique case (setup_sel)
				LCG_REG_THREE: begin
					three_code_d = pwdata[LCG_SRC_LSB +: LCG_SRC_W];
				end
				LCG_REG_FOUR: begin
					four_code_d = pwdata[LCG_SRC_LSB +: LCG_SRC_W];
				end
				LCG_REG_GATE: begin
					// all eight enables are kept; only bits 7..4 reach the gate here
					gate_en_d = pwdata[LCG_GATE_W-1:0];
				end
				LCG_REG_NONE: begin
					// nothing stored
				end
			endcase
		end
	end

	// deliberately outside presetn: the settings come up unknown at power-up
	// and survive every other reset, so software must program them once
	always_ff @(posedge pclk) begin
		three_code_q <= three_code_d;
		four_code_q <= four_code_d;
		gate_en_q <= gate_en_d;
	end

	// source selection; one shared function keeps both paths identical
	// a 6-bit code covers all 64 sources, so no code can fall out of range
	assign line_three_now = lcg_pick(source_bus, three_code_q);
	assign line_four_now = lcg_pick(source_bus, four_code_q);

	// gate zero term combiner
	lcg_gate_zero u_gate_zero (
		.line_three(line_three_now),
		.line_four(line_four_now),
		.gate_en(gate_en_q),
		.gate_zero(gate_now)
	);

	// lines and gate are registered together so they stay aligned in time;
	// costs one cycle of latency from source to core
	always_comb begin
		cell_d.cell_data_line_three = line_three_now;
		cell_d.cell_data_line_four = line_four_now;
		cell_d.gate_zero = gate_now;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cell_q <= LCG_CELL_OUT_RST;
		end else begin
			cell_q <= cell_d;
		end
	end

	// ports straight from flip-flops
	assign pready = pready_q;
	assign prdata = prdata_q;
	assign pslverr = pslverr_q;
	assign cell_out = cell_q;

	// checks on the design's own behaviour
	// bus inputs appear only as conditions or as the value that was written
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// the transfer completes one cycle after setup
	chk_apb_zero_wait: assert property (
		setup_phase |=> pready_q)
		else $error("pready not raised in the access cycle");

	// the answer stands for one cycle only, so a held access never repeats
	chk_apb_one_cycle: assert property (
		pready_q |=> !pready_q)
		else $error("pready held beyond one cycle");

	// a write to the gate register lands in all eight enables
	chk_gate_en_wr: assert property (
		wr_done && setup_sel == LCG_REG_GATE |=> gate_en_q[7:0] == $past(pwdata[7:0]))
		else $error("gate enables not written");

	// an unmapped word answers with an error and zero data
	chk_unmapped_err: assert property (
		access_done && setup_sel == LCG_REG_NONE
		|-> pslverr_q && prdata_q == LCG_UNMAPPED_RD)
		else $error("unmapped access without error");

	// mapped words never answer with an error
	chk_mapped_no_err: assert property (
		access_done && setup_sel != LCG_REG_NONE |-> !pslverr_q)
		else $error("error on a mapped register");

	// a write answers with zero data so stale words never leak
	chk_write_rd_zero: assert property (
		access_done && pwrite |-> prdata_q == LCG_PRDATA_RST)
		else $error("read data not zero on a write");

	// between answers the bus outputs rest at zero
	chk_bus_idle_zero: assert property (
		!pready_q |-> prdata_q == LCG_PRDATA_RST && !pslverr_q)
		else $error("bus outputs not idle");

	// a write to data three select lands in the code
	chk_three_code_wr: assert property (
		wr_done && setup_sel == LCG_REG_THREE |=> three_code_q == $past(pwdata[5:0]))
		else $error("data three code not written");

	// a write to data four select lands in the code
	chk_four_code_wr: assert property (
		wr_done && setup_sel == LCG_REG_FOUR |=> four_code_q == $past(pwdata[5:0]))
		else $error("data four code not written");

	// unimplemented select bits read zero
	chk_sel_upper_zero: assert property (
		access_done && !pwrite && setup_sel inside {LCG_REG_THREE, LCG_REG_FOUR}
		|-> prdata_q[7:6] == 2'b00 && prdata_q[5:0] == (setup_sel == LCG_REG_THREE ?
		three_code_q : four_code_q))
		else $error("select readback wrong");

	// settings change only by a completed write
	// case equality so the unknown power-up value counts as held
	chk_code_hold: assert property (
		!wr_done |=> three_code_q === $past(three_code_q)
		&& four_code_q === $past(four_code_q) && gate_en_q === $past(gate_en_q))
		else $error("configuration changed without a write");

	// true line four enabled and high forces the gate
	chk_in4_true: assert property (
		gate_en_q.g0_in4_true_enable && line_four_now |=> cell_q.gate_zero)
		else $error("true line four not gated");

	// inverted line four enabled and low forces the gate
	chk_in4_inv: assert property (
		gate_en_q.g0_in4_inverted_enable && !line_four_now |=> cell_q.gate_zero)
		else $error("inverted line four not gated");

	// true line three enabled and high forces the gate
	chk_in3_true: assert property (
		gate_en_q.g0_in3_true_enable && line_three_now |=> cell_q.gate_zero)
		else $error("true line three not gated");

	// inverted line three enabled and low forces the gate
	chk_in3_inv: assert property (
		gate_en_q.g0_in3_inverted_enable && !line_three_now |=> cell_q.gate_zero)
		else $error("inverted line three not gated");

	// with no enable set the gate stays low
	chk_gate_none: assert property (
		gate_en_q[7:4] == 4'b0000 |=> !cell_q.gate_zero)
		else $error("gate high with no term enabled");

	// gate never high unless some enabled term was true
	chk_gate_or: assert property (
		!((gate_en_q.g0_in4_true_enable && line_four_now)
		|| (gate_en_q.g0_in4_inverted_enable && !line_four_now)
		|| (gate_en_q.g0_in3_true_enable && line_three_now)
		|| (gate_en_q.g0_in3_inverted_enable && !line_three_now))
		|=> !cell_q.gate_zero)
		else $error("gate high without an active term");

	// lines follow their selected sources one cycle later
	// case equality: the lines are unknown until software programs the codes
	chk_line_follow: assert property (
		1'b1 |=> cell_q.cell_data_line_three === $past(source_bus[three_code_q])
		&& cell_q.cell_data_line_four === $past(source_bus[four_code_q]))
		else $error("data line not from selected source");

endmodule

`default_nettype wire

//--- sim/lcg_input_gating_tb_top.sv
// testbench for the logic cell input gating block: register access over apb
// and the gate zero truth table seen through the selected data lines.
// assumes the design package and top module are compiled before this file.
`timescale 1ns/1ps
`default_nettype none

module lcg_input_gating_tb_top;
	import lcg_pkg::*;

	// clock, reset and apb master drive
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h0000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [3:0] pstrb = 4'h0;
	logic pready;
	logic [31:0] prdata;
	logic pslverr;
	// candidate sources; code 0 and code 63 are the ones used below
	logic [63:0] source_bus = 64'h0000_0000_0000_0000;
	lcg_cell_out_type cell_out;
	// bookkeeping
	int failures = 0;
	int checks_done = 0;
	logic [31:0] rd;
	logic err;
	logic exp_g;
	logic [3:0] gv;
	logic [1:0] lv;

	// 100 MHz clock
	always #5 pclk = ~pclk;

	lcg_input_gating dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.pready(pready), .prdata(prdata), .pslverr(pslverr),
		.source_bus(source_bus), .cell_out(cell_out)
	);

	// one compare, counted; x never matches
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// verdict and end of run
	task automatic test_done;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// one apb transfer; the wait for pready is bounded so a hang ends the run
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
			input logic [3:0] s);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1) begin
			failures++;
			test_done();
		end else begin
			rd = prdata;
			err = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask

	// read and compare both data and error flag
	task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
		apb(1'b0, a, 32'h0000_0000, 4'h0);
		check(rd, exp);
		check({31'h0000_0000, err}, {31'h0000_0000, exp_err});
	endtask

	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		// upper two bits of a select word are dropped; code 0 is the low boundary
		apb(1'b1, LCG_OFS_DATA_THREE_SEL, 32'hFFFF_FFC0, 4'hF);
		rd_chk(LCG_OFS_DATA_THREE_SEL, 32'h0000_0000, 1'b0);
		apb(1'b1, LCG_OFS_DATA_FOUR_SEL, 32'h0000_00FF, 4'hF);
		rd_chk(LCG_OFS_DATA_FOUR_SEL, 32'h0000_003F, 1'b0);
		apb(1'b1, LCG_OFS_GATE_ZERO_EN, 32'h0000_005A, 4'b0001);
		check(rd, 32'h0000_0000);
		rd_chk(LCG_OFS_GATE_ZERO_EN, 32'h0000_005A, 1'b0);
		// a write without the low byte strobe must leave the register alone
		apb(1'b1, LCG_OFS_GATE_ZERO_EN, 32'h0000_00FF, 4'b1110);
		rd_chk(LCG_OFS_GATE_ZERO_EN, 32'h0000_005A, 1'b0);
		// unmapped word answers with an error and zero data
		apb(1'b1, 12'h00C, 32'h0000_00FF, 4'hF);
		rd_chk(12'h00C, 32'h0000_0000, 1'b1);
		// a bus reset in mid-run clears outputs but not the configuration
		@(posedge pclk);
		presetn <= 1'b0;
		@(posedge pclk);
		check({29'h0000_0000, cell_out}, 32'h0000_0000);
		check({31'h0000_0000, pready}, 32'h0000_0000);
		check(prdata, 32'h0000_0000);
		presetn <= 1'b1;
		rd_chk(LCG_OFS_DATA_THREE_SEL, 32'h0000_0000, 1'b0);
		rd_chk(LCG_OFS_DATA_FOUR_SEL, 32'h0000_003F, 1'b0);
		rd_chk(LCG_OFS_GATE_ZERO_EN, 32'h0000_005A, 1'b0);
		// every enable pattern against every pair of line levels; the low
		// enable bits are kept set to show they do not reach the gate
		for (int g = 0; g < 16; g++) begin
			gv = g[3:0];
			apb(1'b1, LCG_OFS_GATE_ZERO_EN, {24'h00_0000, gv, 4'hF}, 4'hF);
			for (int l = 0; l < 4; l++) begin
				lv = l[1:0];
				@(posedge pclk);
				// unselected sources carry the opposite of line three's level to catch a wrong pick
				source_bus <= {lv[1], {62{~lv[0]}}, lv[0]};
				repeat (2) @(posedge pclk);
				#1;
				exp_g = (gv[3] & lv[1]) | (gv[2] & ~lv[1]) | (gv[1] & lv[0]) | (gv[0] & ~lv[0]);
				check({29'h0000_0000, cell_out}, {29'h0000_0000, lv[0], lv[1], exp_g});
			end
		end
		test_done();
	end

endmodule

`default_nettype wire
